// ### design/csw_control.sv
// Comparator, power-path trip, shipping discharge and auto wakeup control.
// Assumes comparator threshold flags and battery level are synchronous.
//
// Function
// - Reference select 0 uses the higher threshold, 1 the lower.
// - Polarity 0: output low while input is above threshold.
// - Polarity 1: output low while input is below threshold.
// - Deglitch delays only falling output edges; rising edges pass at once.
// - Deglitch code 00 disables; 01/10/11 give 1 us, 2 ms, 5 s.
// - Trip with force-off enabled switches both power-path switches off.
// - Forced shutdown drives charger-good low at the same moment.
// - Shipping request discharges the battery sense node for 140 ms.
// - Shipping request bit clears itself when 140 ms have elapsed.
// - Auto wakeup with low battery enables precharge for up to 30 min.
// - Battery recovering during wakeup ends charge and clears the bit.
`timescale 1ns/1ns
module csw_control
  import csw_pkg::*;
#(
  parameter int DEG_SHORT_CYCLES = CSW_DEG_SHORT_CYCLES,
  parameter int DEG_MID_CYCLES = CSW_DEG_MID_CYCLES,
  parameter int DEG_LONG_CYCLES = CSW_DEG_LONG_CYCLES,
  parameter int SHIP_CYCLES = CSW_SHIP_CYCLES,
  parameter int CYCLES_PER_MS = CSW_CYCLES_PER_MS,
  parameter int WAKE_MS = CSW_WAKE_MS,
  parameter logic [6:0] I2C_ADDR = CSW_I2C_ADDR_DEFAULT
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // I2C pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Comparator
  input wire logic comparator_input_above_high,
  input wire logic comparator_input_above_low,
  output logic comparator_output,
  // Power path
  input wire logic converter_enable,
  input wire logic charger_good_source,
  output logic input_side_switch_on,
  output logic output_side_switch_on,
  output logic charger_good_indication,
  // Battery
  input wire logic battery_below_min_system,
  output logic battery_sense_node_discharge,
  output logic wakeup_charge_enable
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (DEG_SHORT_CYCLES < 1 || DEG_MID_CYCLES < 1 || DEG_LONG_CYCLES < 1 ||
      SHIP_CYCLES < 1 || CYCLES_PER_MS < 1 || WAKE_MS < 1)
    $error("csw_control: interval counts must be at least one");

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  function automatic logic hits_options(input logic [7:0] addr);
    return addr == CSW_OPTIONS_OFFSET;
  endfunction

  csw_ctrl_state_type st_reg;
  csw_ctrl_state_type st_next;
  csw_reg_write_type reg_write;
  logic [7:0] reg_pointer;
  logic [7:0] read_data;
  logic write_hit;
  logic above;
  logic raw_high;
  logic [31:0] deg_limit;
  logic ms_tick;

  csw_i2c_slave #(
    .DEVICE_ADDR(I2C_ADDR)
  ) u_i2c (
    .clock(clock),
    .rst_n(rst_n),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_write(reg_write),
    .reg_pointer(reg_pointer),
    .read_data(read_data)
  );

  // Unmapped pointers read as zero and ignore writes
  assign read_data = hits_options(reg_pointer) ? 8'(st_reg.options)
                                               : CSW_UNMAPPED_READ;
  assign write_hit = reg_write.strobe & hits_options(reg_write.addr);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    above = st_reg.options.comparator_reference_select
          ? comparator_input_above_low
          : comparator_input_above_high;
    raw_high = st_reg.options.comparator_output_polarity
             ? above
             : ~above;
    case (st_reg.options.comparator_deglitch_select)
      CSW_DEG_SHORT: deg_limit = 32'(DEG_SHORT_CYCLES);
      CSW_DEG_MID: deg_limit = 32'(DEG_MID_CYCLES);
      CSW_DEG_LONG: deg_limit = 32'(DEG_LONG_CYCLES);
      default: deg_limit = 32'(DEG_SHORT_CYCLES);
    endcase

    // Comparator output with falling-edge deglitch
    if (st_reg.options.comparator_deglitch_select == CSW_DEG_OFF)
    begin
      // Disabled comparator parks high, never trips
      st_next.cmp_out = 1'b1;
      st_next.deg_cnt = '0;
    end
    else if (raw_high)
    begin
      st_next.cmp_out = 1'b1;
      st_next.deg_cnt = '0;
    end
    else if (st_reg.cmp_out)
    begin
      if (st_reg.deg_cnt >= deg_limit - 32'h1)
      begin
        st_next.cmp_out = 1'b0;
        st_next.deg_cnt = '0;
      end
      else
        st_next.deg_cnt = st_reg.deg_cnt + 32'h1;
    end

    // Latched power-path off; held until force-off is cleared
    if (st_reg.cmp_out && !st_next.cmp_out &&
        st_reg.options.trip_power_path_off_enable)
      st_next.latched_off = 1'b1;
    else if (!st_reg.options.trip_power_path_off_enable)
      st_next.latched_off = 1'b0;

    // Shipping discharge timer
    if (st_reg.options.shipping_discharge_request)
    begin
      if (st_reg.ship_cnt >= 32'(SHIP_CYCLES) - 32'h1)
      begin
        st_next.options.shipping_discharge_request = 1'b0;
        st_next.ship_cnt = '0;
      end
      else
        st_next.ship_cnt = st_reg.ship_cnt + 32'h1;
    end
    else
      st_next.ship_cnt = '0;

    // Free-running millisecond time base for the long wakeup interval
    ms_tick = st_reg.ms_pre >= 32'(CYCLES_PER_MS) - 32'h1;
    st_next.ms_pre = ms_tick ? '0 : st_reg.ms_pre + 32'h1;

    // Auto wakeup precharge
    if (st_reg.options.auto_wakeup_enable && battery_below_min_system)
    begin
      if (!st_reg.wake_done && ms_tick)
      begin
        if (st_reg.wake_ms >= 32'(WAKE_MS) - 32'h1)
          st_next.wake_done = 1'b1;
        else
          st_next.wake_ms = st_reg.wake_ms + 32'h1;
      end
    end
    else
    begin
      st_next.wake_ms = '0;
      st_next.wake_done = 1'b0;
    end
    if (st_reg.wake_chg && !battery_below_min_system)
      st_next.options.auto_wakeup_enable = 1'b0;

    // Host write last, so a written set beats a self-clear
    if (write_hit)
    begin
      st_next.options = csw_options_type'(reg_write.data);
      st_next.ship_cnt = '0;
      st_next.wake_ms = '0;
      st_next.wake_done = 1'b0;
    end

    st_next.in_sw = converter_enable & ~st_next.latched_off;
    st_next.out_sw = converter_enable & ~st_next.latched_off;
    st_next.chg_good = charger_good_source &
                       ~st_next.latched_off;
    st_next.discharge = st_next.options.shipping_discharge_request;
    st_next.wake_chg = st_next.options.auto_wakeup_enable &
                       battery_below_min_system &
                       ~st_next.wake_done;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= CSW_CTRL_RESET;
    else
      st_reg <= st_next;
  end

  assign comparator_output = st_reg.cmp_out;
  assign input_side_switch_on = st_reg.in_sw;
  assign output_side_switch_on = st_reg.out_sw;
  assign charger_good_indication = st_reg.chg_good;
  assign battery_sense_node_discharge = st_reg.discharge;
  assign wakeup_charge_enable = st_reg.wake_chg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic cfg_on;
  logic raw_low_short;
  assign cfg_on = st_reg.options.comparator_deglitch_select != CSW_DEG_OFF;
  assign raw_low_short = ~raw_high & st_reg.options.comparator_deglitch_select
                         == CSW_DEG_SHORT;

  chk_high_ref_rise: assert property (
    cfg_on && !st_reg.options.comparator_output_polarity &&
    !st_reg.options.comparator_reference_select &&
    !comparator_input_above_high |=> comparator_output)
    else $error("high reference: output not high below threshold");

  chk_low_ref_rise: assert property (
    cfg_on && !st_reg.options.comparator_output_polarity &&
    st_reg.options.comparator_reference_select &&
    !comparator_input_above_low |=> comparator_output)
    else $error("low reference: output not high below threshold");

  chk_pol_zero_low: assert property (
    $fell(comparator_output) && !$past(st_reg.options.comparator_output_polarity)
    && !$past(st_reg.options.comparator_reference_select)
    |-> $past(comparator_input_above_high))
    else $error("polarity 0: output fell with input below threshold");

  chk_pol_one_low: assert property (
    cfg_on && st_reg.options.comparator_output_polarity &&
    !st_reg.options.comparator_reference_select &&
    comparator_input_above_high |=> comparator_output)
    else $error("polarity 1: output low while input above threshold");

  // Raw input just went low with the count restarted: no instant fall
  chk_short_deglitch: assert property (
    cfg_on && comparator_output && !raw_high && $past(raw_high)
    |=> comparator_output [*8])
    else $error("falling edge passed before deglitch time");

  chk_fall_history: assert property (
    $fell(comparator_output) && $past(raw_low_short)
    |-> $past(raw_low_short, 20))
    else $error("output fell before 1 us of low input");

  chk_disabled_high: assert property (
    st_reg.options.comparator_deglitch_select == CSW_DEG_OFF
    |=> comparator_output)
    else $error("disabled comparator output not high");

  chk_trip_off: assert property (
    $fell(comparator_output) &&
    $past(st_reg.options.trip_power_path_off_enable)
    |-> !input_side_switch_on && !output_side_switch_on)
    else $error("power path not switched off on trip");

  chk_trip_good_low: assert property (
    $fell(comparator_output) &&
    $past(st_reg.options.trip_power_path_off_enable)
    |-> !charger_good_indication)
    else $error("charger good not low on forced shutdown");

  chk_ship_bound: assert property (
    battery_sense_node_discharge |-> st_reg.ship_cnt < 32'(SHIP_CYCLES))
    else $error("discharge interval overran");

  chk_ship_clear: assert property (
    st_reg.options.shipping_discharge_request &&
    st_reg.ship_cnt == 32'(SHIP_CYCLES) - 32'h1 && !write_hit
    |=> !st_reg.options.shipping_discharge_request &&
    !battery_sense_node_discharge)
    else $error("shipping request did not self-clear");

  chk_wake_limit: assert property (
    wakeup_charge_enable |-> st_reg.wake_ms < 32'(WAKE_MS))
    else $error("wakeup charge ran past its limit");

  chk_wake_end: assert property (
    wakeup_charge_enable && !battery_below_min_system && !write_hit
    |=> !wakeup_charge_enable && !st_reg.options.auto_wakeup_enable)
    else $error("wakeup charge did not end on recovery");

  chk_deg_restart: assert property (
    raw_high |=> st_reg.deg_cnt == 32'h0)
    else $error("deglitch count not restarted");

  cov_trip_off: cover property (
    $fell(comparator_output) && !input_side_switch_on);
  cov_ship_done: cover property (
    $fell(st_reg.options.shipping_discharge_request));
  cov_wake_end: cover property (
    $fell(wakeup_charge_enable) && !battery_below_min_system);
  cov_reg_write: cover property (write_hit);

endmodule

// ### design/csw_i2c_slave.sv
// I2C register slave: device address, pointer byte, then data bytes.
// Assumes scl and sda_in are already synchronous to clock.
`timescale 1ns/1ns
module csw_i2c_slave
  import csw_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = CSW_I2C_ADDR_DEFAULT
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register side
  output csw_reg_write_type reg_write,
  output logic [7:0] reg_pointer,
  input wire logic [7:0] read_data
);

  csw_i2c_state_type st_reg;
  csw_i2c_state_type st_next;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  always_comb
  begin
    st_next = st_reg;
    st_next.wr.strobe = 1'b0;
    st_next.scl_prev = scl;
    st_next.sda_prev = sda_in;
    scl_rise = scl & ~st_reg.scl_prev;
    scl_fall = ~scl & st_reg.scl_prev;
    start_seen = scl & st_reg.scl_prev & st_reg.sda_prev & ~sda_in;
    stop_seen = scl & st_reg.scl_prev & ~st_reg.sda_prev & sda_in;
    if (start_seen)
    begin
      st_next.phase = CSW_I2C_ADDR;
      st_next.bit_cnt = 4'h0;
      st_next.sda_oe = 1'b0;
    end
    else if (stop_seen)
    begin
      st_next.phase = CSW_I2C_IDLE;
      st_next.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_reg.phase)
        CSW_I2C_ADDR, CSW_I2C_PTR, CSW_I2C_WDATA:
        begin
          st_next.shift = {st_reg.shift[6:0], sda_in};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        CSW_I2C_RDATA:
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        CSW_I2C_ACK_RDATA:
          // Host not acknowledging ends the read
          if (sda_in)
            st_next.phase = CSW_I2C_IDLE;
        default:
          ;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_reg.phase)
        CSW_I2C_ADDR:
          if (st_reg.bit_cnt == 4'h8)
          begin
            if (st_reg.shift[7:1] == DEVICE_ADDR)
            begin
              st_next.phase = CSW_I2C_ACK_ADDR;
              st_next.sda_oe = 1'b1;
              st_next.is_read = st_reg.shift[0];
            end
            else
              st_next.phase = CSW_I2C_IDLE;
          end
        CSW_I2C_PTR:
          if (st_reg.bit_cnt == 4'h8)
          begin
            st_next.ptr = st_reg.shift;
            st_next.phase = CSW_I2C_ACK_PTR;
            st_next.sda_oe = 1'b1;
          end
        CSW_I2C_WDATA:
          if (st_reg.bit_cnt == 4'h8)
          begin
            st_next.wr = '{strobe: 1'b1, addr: st_reg.ptr,
                           data: st_reg.shift};
            st_next.phase = CSW_I2C_ACK_WDATA;
            st_next.sda_oe = 1'b1;
          end
        CSW_I2C_ACK_ADDR:
        begin
          st_next.bit_cnt = 4'h0;
          if (st_reg.is_read)
          begin
            st_next.phase = CSW_I2C_RDATA;
            st_next.shift = read_data;
            st_next.sda_oe = ~read_data[7];
          end
          else
          begin
            st_next.phase = CSW_I2C_PTR;
            st_next.sda_oe = 1'b0;
          end
        end
        CSW_I2C_ACK_PTR, CSW_I2C_ACK_WDATA:
        begin
          if (st_reg.phase == CSW_I2C_ACK_WDATA)
            st_next.ptr = st_reg.ptr + 8'h01;
          st_next.phase = CSW_I2C_WDATA;
          st_next.bit_cnt = 4'h0;
          st_next.sda_oe = 1'b0;
        end
        CSW_I2C_RDATA:
          if (st_reg.bit_cnt == 4'h8)
          begin
            // Pointer advances early so read_data is ready next byte
            st_next.sda_oe = 1'b0;
            st_next.phase = CSW_I2C_ACK_RDATA;
            st_next.ptr = st_reg.ptr + 8'h01;
          end
          else
          begin
            st_next.shift = {st_reg.shift[6:0], 1'b0};
            st_next.sda_oe = ~st_reg.shift[6];
          end
        CSW_I2C_ACK_RDATA:
        begin
          st_next.phase = CSW_I2C_RDATA;
          st_next.bit_cnt = 4'h0;
          st_next.shift = read_data;
          st_next.sda_oe = ~read_data[7];
        end
        default:
          ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= CSW_I2C_RESET;
    else
      st_reg <= st_next;
  end

  assign sda_out = st_reg.sda_out;
  assign sda_oe = st_reg.sda_oe;
  assign reg_write = st_reg.wr;
  assign reg_pointer = st_reg.ptr;

endmodule

// ### design/csw_pkg.sv
// Shared constants and types for the comparator, shipping and wakeup block.
// Assumes a single 20 MHz clock and an I2C host on the register byte.
package csw_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CSW_OPTIONS_OFFSET = 8'h30;
  localparam logic [7:0] CSW_OPTIONS_RESET = 8'h11;
  localparam logic [7:0] CSW_UNMAPPED_READ = 8'h00;
  // Bus address value is arbitrary
  localparam logic [6:0] CSW_I2C_ADDR_DEFAULT = 7'h2a;

  // ---------------------------------------------------------------
  // Deglitch codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CSW_DEG_OFF = 2'h0;
  localparam logic [1:0] CSW_DEG_SHORT = 2'h1;
  localparam logic [1:0] CSW_DEG_MID = 2'h2;
  localparam logic [1:0] CSW_DEG_LONG = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CSW_CLK_PERIOD_NS = 50;
  localparam int CSW_CYCLES_PER_MS = 1000000 / CSW_CLK_PERIOD_NS;
  localparam int CSW_DEG_SHORT_NS = 1000;
  localparam int CSW_DEG_SHORT_CYCLES =
    (CSW_DEG_SHORT_NS + CSW_CLK_PERIOD_NS - 1) / CSW_CLK_PERIOD_NS;
  localparam int CSW_DEG_MID_MS = 2;
  localparam int CSW_DEG_MID_CYCLES = CSW_DEG_MID_MS * CSW_CYCLES_PER_MS;
  localparam int CSW_DEG_LONG_MS = 5000;
  localparam int CSW_DEG_LONG_CYCLES = CSW_DEG_LONG_MS * CSW_CYCLES_PER_MS;
  localparam int CSW_SHIP_MS = 140;
  localparam int CSW_SHIP_CYCLES = CSW_SHIP_MS * CSW_CYCLES_PER_MS;
  localparam int CSW_WAKE_MIN = 30;
  localparam int CSW_WAKE_MS = CSW_WAKE_MIN * 60000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic comparator_reference_select;
    logic comparator_output_polarity;
    logic [1:0] comparator_deglitch_select;
    logic trip_power_path_off_enable;
    logic reserved;
    logic shipping_discharge_request;
    logic auto_wakeup_enable;
  } csw_options_type;

  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } csw_reg_write_type;

  typedef enum logic [3:0] {
    CSW_I2C_IDLE,
    CSW_I2C_ADDR,
    CSW_I2C_ACK_ADDR,
    CSW_I2C_PTR,
    CSW_I2C_ACK_PTR,
    CSW_I2C_WDATA,
    CSW_I2C_ACK_WDATA,
    CSW_I2C_RDATA,
    CSW_I2C_ACK_RDATA
  } csw_i2c_phase_type;

  typedef struct packed {
    logic scl_prev;
    logic sda_prev;
    csw_i2c_phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic is_read;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_out;
    csw_reg_write_type wr;
  } csw_i2c_state_type;

  localparam csw_i2c_state_type CSW_I2C_RESET = '{
    scl_prev: 1'b1, sda_prev: 1'b1, phase: CSW_I2C_IDLE, default: '0};

  typedef struct packed {
    csw_options_type options;
    logic cmp_out;
    logic [31:0] deg_cnt;
    logic latched_off;
    logic [31:0] ship_cnt;
    logic [31:0] ms_pre;
    logic [31:0] wake_ms;
    logic wake_done;
    logic in_sw;
    logic out_sw;
    logic chg_good;
    logic discharge;
    logic wake_chg;
  } csw_ctrl_state_type;

  localparam csw_ctrl_state_type CSW_CTRL_RESET = '{
    options: csw_options_type'(CSW_OPTIONS_RESET),
    cmp_out: 1'b1, default: '0};

endpackage

// ### sim/comparator_ship_wakeup_control_tb.sv
// Self-checking bench for the option byte and its control outputs.
// Assumes shortened interval parameters; the host model owns the bus.
`timescale 1ns/1ns
module comparator_ship_wakeup_control_tb
  import csw_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic above_high = 1'b0;
  logic above_low = 1'b0;
  logic conv_en = 1'b0;
  logic good_src = 1'b0;
  logic batt_low = 1'b0;
  logic scl, drive_low, sda_out, sda_oe, cmp_out, in_sw, out_sw;
  logic chg_good, dis, wake, ok;
  logic [7:0] q;
  int bad_count = 0;
  int checked = 0;
  // Pull-up: low if either party pulls
  wire logic sda = ~(drive_low | sda_oe);
  always #25 clock = ~clock;
  csw_host_model host (.clock(clock), .sda(sda), .scl(scl),
    .drive_low(drive_low));
  csw_control #(.DEG_SHORT_CYCLES(20), .DEG_MID_CYCLES(40),
    .DEG_LONG_CYCLES(100), .SHIP_CYCLES(50), .CYCLES_PER_MS(4),
    .WAKE_MS(10), .I2C_ADDR(CSW_I2C_ADDR_DEFAULT)) DUT (
    .clock(clock), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .comparator_input_above_high(above_high),
    .comparator_input_above_low(above_low), .comparator_output(cmp_out),
    .converter_enable(conv_en), .charger_good_source(good_src),
    .input_side_switch_on(in_sw), .output_side_switch_on(out_sw),
    .charger_good_indication(chg_good), .battery_below_min_system(batt_low),
    .battery_sense_node_discharge(dis), .wakeup_charge_enable(wake));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] s, input logic [7:0] e,
                       input string m);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic put(input logic [7:0] d);
    host.wr(CSW_OPTIONS_OFFSET, d, ok);
    check(ok, 1'b1, "write not acked");
  endtask
  task automatic get(input logic [7:0] e);
    host.rd(CSW_OPTIONS_OFFSET, q, ok);
    check(ok, 1'b1, "read not acked");
    check(q, e, "option byte read");
  endtask
  task automatic end_of_test();
    $display("Checked %0d, errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_defaults();
    check({cmp_out, dis, wake}, 3'h4, "reset outputs");
    get(CSW_OPTIONS_RESET);
    host.wr(8'h31, 8'hff, ok);
    host.rd(8'h31, q, ok);
    check(q, CSW_UNMAPPED_READ, "unmapped read");
    get(CSW_OPTIONS_RESET);
  endtask
  task automatic t_polarity();
    above_high = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      put({i[1], i[0], 2'h1, 4'h4});
      get({i[1], i[0], 2'h1, 4'h4});
      check(cmp_out, i[1] ^ i[0], "ref or polarity");
    end
    // Only the lower reference flag says above; output must rise
    above_high = 1'b0;
    above_low = 1'b1;
    cyc(2);
    check(cmp_out, 1'b1, "low reference ignored");
  endtask
  task automatic t_deglitch();
    int n;
    for (int c = 1; c < 4; c++)
    begin
      n = (c == 1) ? 20 : (c == 2) ? 40 : 100;
      above_high = 1'b0;
      put({2'h0, c[1:0], 4'h0});
      above_high = 1'b1;
      cyc(n - 5);
      above_high = 1'b0;
      cyc(2);
      above_high = 1'b1;
      cyc(n - 3);
      check(cmp_out, 1'b1, "fell early");
      cyc(6);
      check(cmp_out, 1'b0, "no trip");
      above_high = 1'b0;
      cyc(2);
      check(cmp_out, 1'b1, "rise delayed");
    end
    put(8'h00);
    above_high = 1'b1;
    cyc(120);
    check(cmp_out, 1'b1, "disabled comparator tripped");
  endtask
  task automatic t_force_off();
    conv_en = 1'b1;
    good_src = 1'b1;
    above_high = 1'b0;
    put(8'h18);
    check({in_sw, out_sw, chg_good}, 3'h7, "path not on");
    above_high = 1'b1;
    for (int i = 0; i < 40 && cmp_out !== 1'b0; i++)
      cyc(1);
    check({cmp_out, in_sw, out_sw, chg_good}, 4'h0, "trip");
    above_high = 1'b0;
    cyc(5);
    check({in_sw, out_sw, chg_good}, 3'h0, "latch lost");
    put(8'h10);
    check({in_sw, out_sw, chg_good}, 3'h7, "latch kept");
  endtask
  task automatic t_ship();
    put(8'h12);
    check(dis, 1'b1, "no discharge");
    cyc(45);
    check(dis, 1'b0, "discharge stuck");
    get(8'h10);
  endtask
  task automatic t_wake();
    put(8'h11);
    check(wake, 1'b0, "charge without low battery");
    batt_low = 1'b1;
    cyc(3);
    check(wake, 1'b1, "no wakeup charge");
    batt_low = 1'b0;
    cyc(3);
    check(wake, 1'b0, "charge kept");
    get(8'h10);
    put(8'h11);
    batt_low = 1'b1;
    cyc(3);
    check(wake, 1'b1, "no second wakeup charge");
    // At most eight ms ticks so far: the limit is still ahead
    cyc(28);
    check(wake, 1'b1, "charge ended early");
    cyc(32);
    check(wake, 1'b0, "no time limit");
  endtask
  // Tests need about 10000 cycles; the margin is generous
  initial
  begin
    #(50 * 40000);
    bad_count++;
    end_of_test();
  end
  initial
  begin
    cyc(2);
    rst_n = 1'b1;
    cyc(2);
    t_defaults();
    t_polarity();
    t_deglitch();
    t_force_off();
    t_ship();
    t_wake();
    end_of_test();
  end
endmodule

// ### sim/csw_host_model.sv
// Host side model: bit-banged I2C master for the option byte.
// Assumes sda is resolved by the bench with a pull-up.
`timescale 1ns/1ns
module csw_host_model
  import csw_pkg::*;
(
  // Bus
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic drive_low
);
  // --------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    drive_low = 1'b0;
  end
  // Four clocks a phase clears the three-clock minimum
  task automatic half();
    repeat (4) @(negedge clock);
  endtask
  task automatic start();
    drive_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    drive_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    drive_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    drive_low = 1'b0;
    half();
  endtask
  // Ninth bit always released: target ack on writes, nack on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic nak);
    for (int i = 8; i >= 0; i--)
    begin
      drive_low = (i > 0) ? ~d[i-1] : 1'b0;
      half();
      scl = 1'b1;
      half();
      if (i > 0)
        q[i-1] = sda;
      else
        nak = sda;
      scl = 1'b0;
      half();
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic [2:0] n;
    start();
    xfer({CSW_I2C_ADDR_DEFAULT, 1'b0}, q, n[0]);
    xfer(ptr, q, n[1]);
    xfer(d, q, n[2]);
    stop();
    ok = (n === 3'h0);
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic [3:0] n;
    start();
    xfer({CSW_I2C_ADDR_DEFAULT, 1'b0}, q, n[0]);
    xfer(ptr, q, n[1]);
    start();
    xfer({CSW_I2C_ADDR_DEFAULT, 1'b1}, q, n[2]);
    xfer(8'hff, d, n[3]);
    stop();
    ok = (n === 4'h8);
  endtask
endmodule
